// ==== rtl/mces_chan_lookup.sv ====
// Maps one channel slot onto its bit in a bank of four enable registers.
// Assumes the slot number is stable for the cycle it is looked up.
module mces_chan_lookup (
    input  wire mces_pkg::mces_bank_t enable_regs,
    input  wire logic                 enhanced,
    input  wire logic [1:0]           block_a,
    input  wire logic [1:0]           block_b,
    input  wire mces_pkg::mces_slot_s slot,
    output      logic                 hit
);

    // ----------------------------------------
    // Bit selection
    // ----------------------------------------
    always_comb begin
        hit = 1'b0;
        if (enhanced) begin
            // Register k covers blocks 2k and 2k+1
            hit = enable_regs[slot.block[2:1]][{slot.block[0],
                                                 slot.offset}]; // [RULE8] [RULE9]
        end else if (slot.block == {block_a, 1'b0}) begin
            hit = enable_regs[0][{1'b0, slot.offset}]; // [RULE5] [RULE7]
        end else if (slot.block == {block_b, 1'b1}) begin
            hit = enable_regs[0][{1'b1, slot.offset}]; // [RULE6] [RULE7]
        end
    end

endmodule

// ==== rtl/mces_pkg.sv ====
// Shared constants and types for the multichannel enable select block.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package mces_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int STRB_W   = DATA_W / 8;
    localparam int NUM_REGS = 4;
    localparam int SLOT_W   = 7;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] RX_EN_BASE   = 8'h00;
    localparam logic [ADDR_W-1:0] TX_EN_BASE   = 8'h10;
    localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h20;
    localparam logic [ADDR_W-1:0] STAT_OFS     = 8'h24;
    localparam int                WORD_LSB     = 2;
    localparam int                IDX_W        = 2;
    localparam logic [ADDR_W-1:0] BANK_MASK    = 8'hF0;
    localparam logic [DATA_W-1:0] EN_RESET     = 32'h00000000;
    localparam logic [DATA_W-1:0] CTRL_RESET   = 32'h00000000;
    localparam logic [DATA_W-1:0] CTRL_WMASK   = 32'h0000F73F;

    // ----------------------------------------
    // Transmit multichannel modes
    // ----------------------------------------
    localparam logic [1:0] TX_MODE_ALL       = 2'h0;
    localparam logic [1:0] TX_MODE_SELECT    = 2'h1;
    localparam logic [1:0] TX_MODE_MASKED    = 2'h2;
    localparam logic [1:0] TX_MODE_SYMMETRIC = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] rsvd_hi;
        logic [1:0]  tx_partition_b_block;
        logic [1:0]  tx_partition_a_block;
        logic        rsvd_tx;
        logic        tx_enhanced_channel_mode;
        logic [1:0]  tx_multichannel_mode;
        logic [1:0]  rsvd_mid;
        logic [1:0]  rx_partition_b_block;
        logic [1:0]  rx_partition_a_block;
        logic        rx_enhanced_channel_mode;
        logic        rx_multichannel_select_en;
    } mces_ctrl_s;

    // Slot number split as 16-channel block and offset inside it
    typedef struct packed {
        logic [2:0] block;
        logic [3:0] offset;
    } mces_slot_s;

    typedef struct packed {
        logic rx_enable;
        logic tx_enable;
        logic tx_unmask;
    } mces_dec_s;

    typedef struct packed {
        logic [8:0]  rsvd_hi;
        logic [6:0]  tx_slot;
        logic        rsvd_b;
        logic [6:0]  rx_slot;
        logic [4:0]  rsvd_a;
        mces_dec_s   dec;
    } mces_stat_s;

    typedef logic [NUM_REGS-1:0][DATA_W-1:0] mces_bank_t;

endpackage

// ==== rtl/mces_top.sv ====
// Per-channel enable and mask selection with an AXI4-Lite register file.
// Assumes slot logic on core_clk presents channel numbers with a strobe.
//
// Behaviour
// [RULE1] Four receive enable registers hold one bit for each of 128 receive channels.
// [RULE2] Receive enable bits only matter while receive selection is enabled; transmit mode 11b still uses them for tx enables when it is off.
// [RULE3] Receive bit 0 disables its channel, bit 1 enables it.
// [RULE4] Receive enhanced bit chooses 32 or 128 selectable channels.
// [RULE5] 32-channel mode: low half of register 0 maps partition A block.
// [RULE6] 32-channel mode: high half of register 0 maps partition B block.
// [RULE7] 32-channel mode uses register 0 only; others have no effect.
// [RULE8] 128-channel mode uses all four registers across all partitions.
// [RULE9] 128-channel mode: bit b of register k controls channel 32k+b.
// [RULE10] Four transmit enable registers act only while transmit mode nonzero.
// [RULE11] All eight enable registers are read/write and reset to zero.
// [RULE12] Transmit mode 01b: bit 0 disables and masks, 1 enables and unmasks.
// [RULE13] Transmit mode 10b: all enabled; bit 0 masks, 1 unmasks.
// [RULE14] Mode 11b: enables from receive bits, unmasking from transmit bits.
// [RULE15] Transmit enhanced bit picks 32 or 128 channels, same mapping.
// [RULE16] Each slot yields one combined enable and mask decision.
module mces_top (
    input  wire  logic                          core_clk,
    input  wire  logic                          sys_rst,
    // AXI4-Lite write address
    input  wire  logic                          s_axi_awvalid,
    output       logic                          s_axi_awready,
    input  wire  logic [mces_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire  logic [2:0]                    s_axi_awprot,
    // AXI4-Lite write data
    input  wire  logic                          s_axi_wvalid,
    output       logic                          s_axi_wready,
    input  wire  logic [mces_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire  logic [mces_pkg::STRB_W-1:0]   s_axi_wstrb,
    // AXI4-Lite write response
    output       logic                          s_axi_bvalid,
    input  wire  logic                          s_axi_bready,
    output       logic [1:0]                    s_axi_bresp,
    // AXI4-Lite read address
    input  wire  logic                          s_axi_arvalid,
    output       logic                          s_axi_arready,
    input  wire  logic [mces_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire  logic [2:0]                    s_axi_arprot,
    // AXI4-Lite read data
    output       logic                          s_axi_rvalid,
    input  wire  logic                          s_axi_rready,
    output       logic [mces_pkg::DATA_W-1:0]   s_axi_rdata,
    output       logic [1:0]                    s_axi_rresp,
    // Receive slot logic
    input  wire  logic                          rx_slot_valid,
    input  wire  logic [mces_pkg::SLOT_W-1:0]   rx_slot_num,
    output       logic                          rx_chan_enable,
    // Transmit slot logic
    input  wire  logic                          tx_slot_valid,
    input  wire  logic [mces_pkg::SLOT_W-1:0]   tx_slot_num,
    output       logic                          tx_chan_enable,
    output       logic                          tx_chan_unmask
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    mces_pkg::mces_bank_t          rx_channel_enable_regs;
    mces_pkg::mces_bank_t          tx_channel_enable_regs;
    mces_pkg::mces_ctrl_s          multichannel_control_reg;
    mces_pkg::mces_dec_s           decision;
    mces_pkg::mces_dec_s           next_rx_dec;
    mces_pkg::mces_dec_s           next_tx_dec;
    logic [mces_pkg::SLOT_W-1:0]   rx_slot_seen;
    logic [mces_pkg::SLOT_W-1:0]   tx_slot_seen;

    logic                          aw_held;
    logic                          w_held;
    logic [mces_pkg::ADDR_W-1:0]   aw_addr_q;
    logic [mces_pkg::DATA_W-1:0]   w_data_q;
    logic [mces_pkg::STRB_W-1:0]   w_strb_q;
    logic                          wr_fire;
    logic                          wr_rx_hit;
    logic                          wr_tx_hit;
    logic                          wr_ctrl_hit;
    logic                          wr_ok;
    logic [mces_pkg::IDX_W-1:0]    wr_idx;

    logic [mces_pkg::DATA_W-1:0]   rd_word;
    logic                          rd_ok;
    logic [mces_pkg::IDX_W-1:0]    rd_idx;

    logic                          rx_lookup_hit;
    logic                          tx_rx_lookup_hit;
    logic                          tx_lookup_hit;
    logic                          tx_symmetric;
    logic [1:0]                    tx_blk_a;
    logic [1:0]                    tx_blk_b;
    mces_pkg::mces_stat_s          status_word;

    // ----------------------------------------
    // Byte-lane merge
    // ----------------------------------------
    function automatic logic [mces_pkg::DATA_W-1:0] merge_bytes(
        input logic [mces_pkg::DATA_W-1:0] old_word,
        input logic [mces_pkg::DATA_W-1:0] new_word,
        input logic [mces_pkg::STRB_W-1:0] strb
    );
        logic [mces_pkg::DATA_W-1:0] result;
        result = old_word;
        for (int i = 0; i < mces_pkg::STRB_W; i++) begin
            if (strb[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    // Address and data are latched independently so either may come first
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx        = aw_addr_q[mces_pkg::WORD_LSB +: mces_pkg::IDX_W];
    assign wr_rx_hit     = (aw_addr_q & mces_pkg::BANK_MASK)
                           == mces_pkg::RX_EN_BASE;
    assign wr_tx_hit     = (aw_addr_q & mces_pkg::BANK_MASK)
                           == mces_pkg::TX_EN_BASE;
    assign wr_ctrl_hit   = aw_addr_q == mces_pkg::CTRL_OFS;
    // Status is read only; a write there is accepted and dropped
    assign wr_ok         = wr_rx_hit || wr_tx_hit || wr_ctrl_hit
                           || aw_addr_q == mces_pkg::STAT_OFS;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held   <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            w_held   <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held   <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= mces_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? mces_pkg::RESP_OKAY
                                  : mces_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Enable and control registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_channel_enable_regs <= {mces_pkg::NUM_REGS{
                                       mces_pkg::EN_RESET}}; // [RULE11]
        end else if (wr_fire && wr_rx_hit) begin
            rx_channel_enable_regs[wr_idx] <= merge_bytes(
                rx_channel_enable_regs[wr_idx], w_data_q,
                w_strb_q); // [RULE1] [RULE11]
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_channel_enable_regs <= {mces_pkg::NUM_REGS{
                                       mces_pkg::EN_RESET}}; // [RULE11]
        end else if (wr_fire && wr_tx_hit) begin
            tx_channel_enable_regs[wr_idx] <= merge_bytes(
                tx_channel_enable_regs[wr_idx], w_data_q,
                w_strb_q); // [RULE10] [RULE11]
        end
    end

    // Reserved control bits stay zero whatever is written
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            multichannel_control_reg <= mces_pkg::CTRL_RESET;
        end else if (wr_fire && wr_ctrl_hit) begin
            multichannel_control_reg <= merge_bytes(
                multichannel_control_reg, w_data_q, w_strb_q)
                & mces_pkg::CTRL_WMASK;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[mces_pkg::WORD_LSB +: mces_pkg::IDX_W];

    always_comb begin
        status_word         = '0;
        status_word.dec     = decision;
        status_word.rx_slot = rx_slot_seen;
        status_word.tx_slot = tx_slot_seen;
    end

    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        if ((s_axi_araddr & mces_pkg::BANK_MASK) == mces_pkg::RX_EN_BASE) begin
            rd_word = rx_channel_enable_regs[rd_idx];
        end else if ((s_axi_araddr & mces_pkg::BANK_MASK)
                     == mces_pkg::TX_EN_BASE) begin
            rd_word = tx_channel_enable_regs[rd_idx];
        end else if (s_axi_araddr == mces_pkg::CTRL_OFS) begin
            rd_word = multichannel_control_reg;
        end else if (s_axi_araddr == mces_pkg::STAT_OFS) begin
            rd_word = status_word;
        end else begin
            rd_ok   = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= mces_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? mces_pkg::RESP_OKAY
                                  : mces_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Channel lookups
    // ----------------------------------------
    mces_chan_lookup u_rx_lookup (
        .enable_regs (rx_channel_enable_regs),
        .enhanced    (multichannel_control_reg.rx_enhanced_channel_mode),
        .block_a     (multichannel_control_reg.rx_partition_a_block),
        .block_b     (multichannel_control_reg.rx_partition_b_block),
        .slot        (rx_slot_num),
        .hit         (rx_lookup_hit)
    ); // [RULE4]

    // Symmetric mode borrows the receive bank for the transmit slot
    mces_chan_lookup u_tx_rx_lookup (
        .enable_regs (rx_channel_enable_regs),
        .enhanced    (multichannel_control_reg.rx_enhanced_channel_mode),
        .block_a     (multichannel_control_reg.rx_partition_a_block),
        .block_b     (multichannel_control_reg.rx_partition_b_block),
        .slot        (tx_slot_num),
        .hit         (tx_rx_lookup_hit)
    ); // [RULE14]

    assign tx_symmetric = multichannel_control_reg.tx_multichannel_mode
                          == mces_pkg::TX_MODE_SYMMETRIC;
    // In symmetric mode the transmit blocks follow the receive fields
    assign tx_blk_a = tx_symmetric
                      ? multichannel_control_reg.rx_partition_a_block
                      : multichannel_control_reg.tx_partition_a_block;
    assign tx_blk_b = tx_symmetric
                      ? multichannel_control_reg.rx_partition_b_block
                      : multichannel_control_reg.tx_partition_b_block;

    mces_chan_lookup u_tx_lookup (
        .enable_regs (tx_channel_enable_regs),
        .enhanced    (multichannel_control_reg.tx_enhanced_channel_mode),
        .block_a     (tx_blk_a),
        .block_b     (tx_blk_b),
        .slot        (tx_slot_num),
        .hit         (tx_lookup_hit)
    ); // [RULE15]

    // ----------------------------------------
    // Per-slot decisions
    // ----------------------------------------
    always_comb begin
        next_rx_dec           = decision;
        // Selection off means every channel is received
        next_rx_dec.rx_enable = 1'b1;
        if (multichannel_control_reg.rx_multichannel_select_en) begin
            next_rx_dec.rx_enable = rx_lookup_hit; // [RULE2] [RULE3]
        end
    end

    always_comb begin
        next_tx_dec = decision;
        unique case (multichannel_control_reg.tx_multichannel_mode)
            mces_pkg::TX_MODE_ALL: begin
                next_tx_dec.tx_enable = 1'b1; // [RULE10]
                next_tx_dec.tx_unmask = 1'b1;
            end
            mces_pkg::TX_MODE_SELECT: begin
                next_tx_dec.tx_enable = tx_lookup_hit; // [RULE12]
                next_tx_dec.tx_unmask = tx_lookup_hit;
            end
            mces_pkg::TX_MODE_MASKED: begin
                next_tx_dec.tx_enable = 1'b1; // [RULE13]
                next_tx_dec.tx_unmask = tx_lookup_hit;
            end
            mces_pkg::TX_MODE_SYMMETRIC: begin
                next_tx_dec.tx_enable = tx_rx_lookup_hit; // [RULE14]
                next_tx_dec.tx_unmask = tx_lookup_hit;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            decision.rx_enable <= 1'b0;
            rx_slot_seen       <= '0;
        end else if (rx_slot_valid) begin
            decision.rx_enable <= next_rx_dec.rx_enable; // [RULE16]
            rx_slot_seen       <= rx_slot_num;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            decision.tx_enable <= 1'b0;
            decision.tx_unmask <= 1'b0;
            tx_slot_seen       <= '0;
        end else if (tx_slot_valid) begin
            decision.tx_enable <= next_tx_dec.tx_enable; // [RULE16]
            decision.tx_unmask <= next_tx_dec.tx_unmask;
            tx_slot_seen       <= tx_slot_num;
        end
    end

    assign rx_chan_enable = decision.rx_enable;
    assign tx_chan_enable = decision.tx_enable;
    assign tx_chan_unmask = decision.tx_unmask;

endmodule

// ==== tb/mces_chk.sv ====
// Port-level assertions for the enable select block.
// Assumes it is bound onto mces_top and sees only its ports.
module mces_chk (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        rx_slot_valid,
    input wire logic        rx_chan_enable,
    input wire logic        tx_slot_valid,
    input wire logic        tx_chan_enable,
    input wire logic        tx_chan_unmask
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence aw_w_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    resp_gate_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while response pending");
    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    rx_hold_a: assert property (
        !rx_slot_valid |=> $stable(rx_chan_enable))
        else $error("rx decision moved without strobe");
    tx_hold_a: assert property (
        !tx_slot_valid |=> $stable({tx_chan_enable, tx_chan_unmask}))
        else $error("tx decision moved without strobe");
    reset_clear_a: assert property ($fell(sys_rst) |-> !s_axi_bvalid
        && !s_axi_rvalid && !rx_chan_enable && !tx_chan_enable)
        else $error("outputs not cleared by reset");
endmodule

bind mces_top mces_chk chk (.*);

// ==== tb/mces_slot_model.sv ====
// Channel slot logic model: strobes one rx and one tx slot at a time.
// Assumes the caller waits for each strobe to finish.
module mces_slot_model (
    input wire logic core_clk,
    output     logic rx_slot_valid,
    output     logic [6:0] rx_slot_num,
    output     logic tx_slot_valid,
    output     logic [6:0] tx_slot_num
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_slot_valid = 1'b0;
        tx_slot_valid = 1'b0;
        rx_slot_num = 7'h00;
        tx_slot_num = 7'h00;
    end
    // Idle slot numbers invert so a stale value never looks valid
    task automatic strobe(input logic [6:0] r, t, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        rx_slot_valid <= 1'b1;
        tx_slot_valid <= 1'b1;
        rx_slot_num <= r;
        tx_slot_num <= t;
        @(posedge core_clk);
        rx_slot_valid <= 1'b0;
        tx_slot_valid <= 1'b0;
        rx_slot_num <= ~r;
        tx_slot_num <= ~t;
    endtask
endmodule

// ==== tb/tb_multichannel_enable_select.sv ====
// Self-checking bench: register file over AXI4-Lite and slot decisions.
// Assumes mces_top, mces_pkg and the slot model are compiled first.
module tb_multichannel_enable_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, rx_slot_valid, tx_slot_valid;
    logic rx_chan_enable, tx_chan_enable, tx_chan_unmask;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [6:0] rx_slot_num, tx_slot_num;
    mces_pkg::mces_bank_t rxm, txm;
    mces_pkg::mces_ctrl_s c;
    logic er, et, eu;
    int fails = 0, compares = 0, cyc = 0, seed = 59;
    always #5 core_clk = ~core_clk;
    mces_top dut (.*);
    mces_slot_model slots (.*);
    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic chk_reg(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_dec(input string nm, input logic e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ah, wh, bh;
        @(posedge core_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            @(negedge core_clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ah, dh;
        @(posedge core_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        dh = 1'b0;
        while (!dh) begin
            @(negedge core_clk);
            ah = s_axi_arvalid && s_axi_arready;
            dh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ah) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic pick(input mces_pkg::mces_bank_t b,
        input logic enh, input logic [1:0] pa, pb, input logic [6:0] s);
        if (enh) return b[s[6:5]][s[4:0]];
        if (s[6:4] == {pa, 1'b0}) return b[0][{1'b0, s[3:0]}];
        if (s[6:4] == {pb, 1'b1}) return b[0][{1'b1, s[3:0]}];
        return 1'b0;
    endfunction
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Ceiling is about four times the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            tally_and_finish;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            rd(8'(k * 4));
            chk_reg("reset value", 32'h00000000, d);
        end
        $display("test reset done");
        wr(8'h30, 32'hFFFFFFFF);
        chk_reg("unmapped bresp", 32'(mces_pkg::RESP_SLVERR), 32'(r));
        rd(8'h30);
        chk_reg("unmapped rresp", 32'(mces_pkg::RESP_SLVERR), 32'(r));
        chk_reg("unmapped rdata", 32'h00000000, d);
        $display("test unmapped done");
        for (int it = 0; it < 24; it++) begin
            for (int k = 0; k < 8; k++) begin
                d = (it == 1) ? 32'hFFFFFFFF : $random(seed);
                if (k < 4) rxm[k] = d;
                else txm[k - 4] = d;
                wr(8'(k * 4), d);
            end
            c = mces_pkg::mces_ctrl_s'($random(seed) & mces_pkg::CTRL_WMASK);
            c.tx_multichannel_mode = 2'(it);
            c.tx_enhanced_channel_mode = it[2];
            c.rx_enhanced_channel_mode = it[2] ^ it[3];
            c.rx_multichannel_select_en = (it % 5 != 0);
            wr(mces_pkg::CTRL_OFS, c);
            for (int k = 0; k < 8; k++) begin
                rd(8'(k * 4));
                chk_reg("enable reg", k < 4 ? rxm[k] : txm[k - 4], d);
            end
            for (int s = 0; s < 128; s++) begin
                slots.strobe(7'(s), 7'(s * 5 + it), it % 3);
                #1;
                er = !c.rx_multichannel_select_en || pick(rxm,
                    c.rx_enhanced_channel_mode, c.rx_partition_a_block,
                    c.rx_partition_b_block, 7'(s));
                eu = pick(txm, c.tx_enhanced_channel_mode,
                    c.tx_multichannel_mode == 2'h3 ? c.rx_partition_a_block
                    : c.tx_partition_a_block, c.tx_multichannel_mode ==
                    2'h3 ? c.rx_partition_b_block : c.tx_partition_b_block,
                    7'(s * 5 + it));
                et = pick(rxm, c.rx_enhanced_channel_mode,
                    c.rx_partition_a_block, c.rx_partition_b_block,
                    7'(s * 5 + it));
                case (c.tx_multichannel_mode)
                    2'h0: {et, eu} = 2'b11;
                    2'h1: et = eu;
                    2'h2: et = 1'b1;
                    default: ;
                endcase
                chk_dec("rx enable", er, rx_chan_enable);
                chk_dec("tx enable", et, tx_chan_enable);
                chk_dec("tx unmask", eu, tx_chan_unmask);
            end
            $display("test config %0d done", it);
        end
        tally_and_finish;
    end
endmodule
